// *** msc_defs.vh ***
// register map, field positions, reset values and timing figures of the monitor sequencer
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MSC_A_CFG       8'h00
`define MSC_A_STAT      8'h01
`define MSC_A_MASK      8'h03
`define MSC_A_RATE      8'h07
`define MSC_A_OFF       8'h08
`define MSC_A_ONESHOT   8'h09
`define MSC_A_DEEP      8'h0a
`define MSC_A_ADV       8'h0b
`define MSC_A_BUSY      8'h0c
`define MSC_A_RD_BASE   8'h20
`define MSC_A_RD_LAST   8'h27
`define MSC_A_LIM_BASE  8'h2a
`define MSC_A_LIM_LAST  8'h39
`define MSC_A_MAKER     8'h3e
`define MSC_A_REV       8'h3f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MSC_CFG_RST     8'h08
`define MSC_ZERO8       8'h00
`define MSC_ZERO16      16'h0000
`define MSC_MAKER_VAL   8'h5a
`define MSC_REV_VAL     8'h03

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MSC_CFG_START   0
`define MSC_CFG_INTEN   1
`define MSC_CFG_INTCLR  3
`define MSC_CFG_INIT    7
`define MSC_ADV_EXTREF  0
`define MSC_ADV_MODE_HI 2
`define MSC_ADV_MODE_LO 1
`define MSC_RATE_CONT   0
`define MSC_DEEP_EN     0
`define MSC_BUSY_CONV   0
`define MSC_BUSY_NRDY   1

// ----------------------------------------------------------------
// modes, channel numbers, limit slots
// ----------------------------------------------------------------
`define MSC_MODE_ALL_V  2'd1
`define MSC_MODE_FOUR   2'd2
`define MSC_MODE_SIX    2'd3
`define MSC_TEMP_CH     3'd7
`define MSC_LIM_HOT     4'd14
`define MSC_LIM_HYST    4'd15
`define MSC_V_LAST_M2   3
`define MSC_V_LAST_M3   5
`define MSC_V_LAST_M0   6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MSC_CLK_MHZ     100
`define MSC_VOLT_US     12200
`define MSC_TEMP_US     3600
`define MSC_LP_US       728000
`define MSC_POR_US      33000

`endif

// *** msc_monitor.v ***
// sequencer, limit checking, alert pin and register file of the eight-input monitor
`include "msc_defs.vh"
`default_nettype none

module msc_monitor #(
	parameter [26:0] VOLT_CYC = `MSC_VOLT_US * `MSC_CLK_MHZ,
	parameter [26:0] TEMP_CYC = `MSC_TEMP_US * `MSC_CLK_MHZ,
	parameter [26:0] LP_CYC   = `MSC_LP_US * `MSC_CLK_MHZ,
	parameter [26:0] POR_CYC  = `MSC_POR_US * `MSC_CLK_MHZ
) (
	input  wire        clk_sys,
	input  wire        arst_n,
	input  wire        scl_pin,
	input  wire        sda_pin,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [11:0] conv_result,
	output wire [15:0] reg_rdata,
	output wire        conv_start,
	output wire [2:0]  conv_chan,
	output wire        conv_temp,
	output wire        vref_ext,
	output wire        shutdown,
	output wire        deep_sleep,
	output wire        alert_pin_out,
	output wire        alert_pin_oe_n
);

	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam [1:0] S_IDLE = 2'd0;
	localparam [1:0] S_CONV = 2'd1;
	localparam [1:0] S_UPD  = 2'd2;
	localparam [1:0] S_WAIT = 2'd3;

	localparam [26:0] VOLT_LAST = VOLT_CYC - 27'd1;
	localparam [26:0] TEMP_LAST = TEMP_CYC - 27'd1;
	localparam [26:0] LP_LAST   = LP_CYC - 27'd1;
	localparam [26:0] POR_LAST  = POR_CYC - 27'd1;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [7:0]  cfg_reg;
	reg [7:0]  stat_reg;
	reg [7:0]  mask_reg;
	reg [7:0]  rate_reg;
	reg [7:0]  off_reg;
	reg [7:0]  deep_reg;
	reg [7:0]  adv_reg;
	reg [15:0] rdata_reg;
	reg [15:0] rd_mem [0:7];
	reg [7:0]  lim_mem [0:15];

	reg [1:0]  state_reg;
	reg [2:0]  cur_reg;
	reg [26:0] slot_cnt_reg;
	reg [26:0] period_cnt_reg;
	reg [26:0] por_cnt_reg;
	reg        nrdy_reg;
	reg        os_pend_reg;
	reg [11:0] pend_reg;
	reg        conv_start_reg;
	reg        conv_temp_reg;
	reg        temp_armed_reg;
	reg        stat_seen_reg;
	reg        alert_oe_n_reg;
	reg        alert_out_reg;
	reg        vref_ext_reg;
	reg        shutdown_reg;
	reg        deep_sleep_reg;

	reg        scl_s1_reg;
	reg        scl_s2_reg;
	reg        sda_s1_reg;
	reg        sda_s2_reg;
	reg        sda_prev_reg;
	reg        bus_act_reg;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// lowest enabled channel at or above a starting index, {found, index}
	function [3:0] msc_next;
		input [7:0] en;
		input [3:0] from;
		integer     k;
		begin
			msc_next = 4'h0;
			for (k = 7; k >= 0; k = k - 1) begin
				if (en[k] && (k >= from)) begin
					msc_next = {1'b1, k[2:0]};
				end
			end
		end
	endfunction

	wire [1:0] mode      = adv_reg[`MSC_ADV_MODE_HI:`MSC_ADV_MODE_LO];
	wire       has_temp  = (mode != `MSC_MODE_ALL_V);
	wire       start_b   = cfg_reg[`MSC_CFG_START];
	wire       intclr_b  = cfg_reg[`MSC_CFG_INTCLR];
	wire       deep_b    = deep_reg[`MSC_DEEP_EN];
	wire       running   = start_b & ~intclr_b & ~deep_b;
	wire       wr_cfg    = reg_wr && (reg_addr == `MSC_A_CFG);
	wire       soft_init = wr_cfg && reg_wdata[`MSC_CFG_INIT];
	wire       wr_os     = reg_wr && (reg_addr == `MSC_A_ONESHOT);
	wire       rd_stat   = reg_rd && (reg_addr == `MSC_A_STAT);
	wire [7:0] lim_off   = reg_addr - `MSC_A_LIM_BASE;
	wire       in_lim    = (reg_addr >= `MSC_A_LIM_BASE) && (reg_addr <= `MSC_A_LIM_LAST);
	wire       in_rd     = (reg_addr >= `MSC_A_RD_BASE) && (reg_addr <= `MSC_A_RD_LAST);

	// ----------------------------------------------------------------
	// channel mix per mode
	// ----------------------------------------------------------------
	wire [7:0] chan_en;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_chan
			// voltage inputs allowed by the mode, temperature on the last slot
			wire v_ok = (mode == `MSC_MODE_ALL_V) ||
				((mode == `MSC_MODE_FOUR) && (gi <= `MSC_V_LAST_M2)) ||
				((mode == `MSC_MODE_SIX) && (gi <= `MSC_V_LAST_M3)) ||
				((mode == 2'd0) && (gi <= `MSC_V_LAST_M0));
			wire t_ok = has_temp && (gi == `MSC_TEMP_CH);
			assign chan_en[gi] = (v_ok | t_ok) & ~off_reg[gi];
		end
	endgenerate

	wire [3:0] first_ch  = msc_next(chan_en, 4'h0);
	wire [3:0] next_ch   = msc_next(chan_en, {1'b0, cur_reg} + 4'h1);
	wire       upd_fire  = (state_reg == S_UPD) && !bus_act_reg;
	wire       first_tmp = has_temp && (first_ch[2:0] == `MSC_TEMP_CH);
	wire       next_tmp  = has_temp && (next_ch[2:0] == `MSC_TEMP_CH);

	// ----------------------------------------------------------------
	// limit comparison of the pending result
	// ----------------------------------------------------------------
	wire [7:0] lim_hi  = lim_mem[{cur_reg, 1'b0}];
	wire [7:0] lim_lo  = lim_mem[{cur_reg, 1'b1}];
	wire [7:0] lim_hot = lim_mem[`MSC_LIM_HOT];
	wire [7:0] lim_hys = lim_mem[`MSC_LIM_HYST];
	// voltage limits weigh the top eight bits of the 12-bit reading
	wire       v_fault = (pend_reg[11:4] > lim_hi) || (pend_reg[11:4] <= lim_lo);
	// limits are whole degrees, readings half degrees: double the limit
	wire       t_hot   = $signed(pend_reg[8:0]) > $signed({lim_hot, 1'b0});
	wire       t_cool  = $signed(pend_reg[8:0]) <= $signed({lim_hys, 1'b0});
	wire       t_fault = t_hot | temp_armed_reg;
	wire       fault   = conv_temp_reg ? t_fault : v_fault;
	wire [7:0] set_bits = (upd_fire && fault) ? (8'h01 << cur_reg) : `MSC_ZERO8;

	// ----------------------------------------------------------------
	// serial-line watch for transaction activity
	// ----------------------------------------------------------------
	// only the second stage and its one-cycle delayed copy are looked at; start and stop framing mark the transaction
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			scl_s1_reg   <= 1'b1;
			scl_s2_reg   <= 1'b1;
			sda_s1_reg   <= 1'b1;
			sda_s2_reg   <= 1'b1;
			sda_prev_reg <= 1'b1;
			bus_act_reg  <= 1'b0;
		end else begin
			scl_s1_reg   <= scl_pin;
			scl_s2_reg   <= scl_s1_reg;
			sda_s1_reg   <= sda_pin;
			sda_s2_reg   <= sda_s1_reg;
			sda_prev_reg <= sda_s2_reg;
			if (scl_s2_reg && sda_prev_reg && !sda_s2_reg) begin
				bus_act_reg <= 1'b1;
			end else if (scl_s2_reg && !sda_prev_reg && sda_s2_reg) begin
				bus_act_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	// init writes land as defaults in the same cycle, so bit 7 never reads back set
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cfg_reg  <= `MSC_CFG_RST;
			mask_reg <= `MSC_ZERO8;
			rate_reg <= `MSC_ZERO8;
			off_reg  <= `MSC_ZERO8;
			deep_reg <= `MSC_ZERO8;
			adv_reg  <= `MSC_ZERO8;
		end else if (soft_init) begin
			cfg_reg  <= `MSC_CFG_RST;
			mask_reg <= `MSC_ZERO8;
			rate_reg <= `MSC_ZERO8;
			off_reg  <= `MSC_ZERO8;
			deep_reg <= `MSC_ZERO8;
			adv_reg  <= `MSC_ZERO8;
		end else if (reg_wr) begin
			case (reg_addr)
				`MSC_A_CFG:  cfg_reg  <= reg_wdata;
				`MSC_A_MASK: mask_reg <= reg_wdata;
				`MSC_A_RATE: rate_reg <= reg_wdata;
				`MSC_A_OFF:  off_reg  <= reg_wdata;
				`MSC_A_DEEP: deep_reg <= reg_wdata;
				`MSC_A_ADV:  adv_reg  <= reg_wdata;
				default:     cfg_reg  <= cfg_reg;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// readings and limits: no reset, kept across init
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (upd_fire) begin
			if (conv_temp_reg) begin
				rd_mem[cur_reg] <= {7'h00, pend_reg[8:0]};
			end else begin
				rd_mem[cur_reg] <= {4'h0, pend_reg};
			end
		end
		if (reg_wr && in_lim) begin
			lim_mem[lim_off[3:0]] <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// limit status, temperature re-arm, alert pin
	// ----------------------------------------------------------------
	// a fault landing with the clearing read stays set
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			stat_reg       <= `MSC_ZERO8;
			temp_armed_reg <= 1'b0;
			stat_seen_reg  <= 1'b0;
			alert_oe_n_reg <= 1'b1;
			alert_out_reg  <= 1'b0;
		end else begin
			alert_out_reg <= 1'b0;
			if (soft_init) begin
				stat_reg       <= `MSC_ZERO8;
				temp_armed_reg <= 1'b0;
				stat_seen_reg  <= 1'b0;
			end else begin
				stat_reg <= (rd_stat ? `MSC_ZERO8 : stat_reg) | set_bits;
				if (upd_fire && conv_temp_reg && t_hot) begin
					temp_armed_reg <= 1'b1;
					stat_seen_reg  <= 1'b0;
				end else if (upd_fire && conv_temp_reg && t_cool && stat_seen_reg) begin
					temp_armed_reg <= 1'b0;
				end else if (rd_stat) begin
					stat_seen_reg <= 1'b1;
				end
			end
			// start bit plays no part here, so stopping the loop keeps an alert
			alert_oe_n_reg <= ~(cfg_reg[`MSC_CFG_INTEN] & ~intclr_b &
				|(stat_reg & ~mask_reg));
		end
	end

	// ----------------------------------------------------------------
	// power-up not-ready window
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			por_cnt_reg <= 27'd0;
			nrdy_reg    <= 1'b1;
		end else if (soft_init) begin
			por_cnt_reg <= 27'd0;
			nrdy_reg    <= 1'b1;
		end else if (nrdy_reg) begin
			if (por_cnt_reg >= POR_LAST) begin
				nrdy_reg <= 1'b0;
			end else begin
				por_cnt_reg <= por_cnt_reg + 27'd1;
			end
		end
	end

	// ----------------------------------------------------------------
	// conversion sequencer
	// ----------------------------------------------------------------
	// the slot timer stands in for the converter; the result is taken at slot end
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg      <= S_IDLE;
			cur_reg        <= 3'd0;
			slot_cnt_reg   <= 27'd0;
			period_cnt_reg <= 27'd0;
			os_pend_reg    <= 1'b0;
			pend_reg       <= 12'h000;
			conv_start_reg <= 1'b0;
			conv_temp_reg  <= 1'b0;
		end else begin
			conv_start_reg <= 1'b0;
			period_cnt_reg <= period_cnt_reg + 27'd1;
			if (wr_os && !start_b) begin
				os_pend_reg <= 1'b1;
			end
			if (soft_init) begin
				state_reg   <= S_IDLE;
				os_pend_reg <= 1'b0;
			end else begin
				case (state_reg)
					S_IDLE: begin
						if ((running | os_pend_reg) && first_ch[3]) begin
							cur_reg        <= first_ch[2:0];
							conv_temp_reg  <= first_tmp;
							slot_cnt_reg   <= first_tmp ? TEMP_LAST : VOLT_LAST;
							conv_start_reg <= 1'b1;
							period_cnt_reg <= 27'd0;
							state_reg      <= S_CONV;
						end else if (!first_ch[3]) begin
							os_pend_reg <= 1'b0;
						end
					end
					S_CONV: begin
						if (!running && !os_pend_reg) begin
							state_reg <= S_IDLE;
						end else if (slot_cnt_reg == 27'd0) begin
							pend_reg  <= conv_result;
							state_reg <= S_UPD;
						end else begin
							slot_cnt_reg <= slot_cnt_reg - 27'd1;
						end
					end
					S_UPD: begin
						if (!bus_act_reg) begin
							if (next_ch[3]) begin
								cur_reg        <= next_ch[2:0];
								conv_temp_reg  <= next_tmp;
								slot_cnt_reg   <= next_tmp ? TEMP_LAST : VOLT_LAST;
								conv_start_reg <= 1'b1;
								state_reg      <= S_CONV;
							end else if (os_pend_reg) begin
								os_pend_reg <= 1'b0;
								state_reg   <= S_IDLE;
							end else if (rate_reg[`MSC_RATE_CONT]) begin
								state_reg <= S_IDLE;
							end else begin
								state_reg <= S_WAIT;
							end
						end
					end
					S_WAIT: begin
						if (!running || (period_cnt_reg >= LP_LAST)) begin
							state_reg <= S_IDLE;
						end
					end
					default: state_reg <= S_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// register read port and pin flops
	// ----------------------------------------------------------------
	reg [15:0] rd_mux;
	always @* begin
		rd_mux = `MSC_ZERO16;
		if (in_rd) begin
			rd_mux = rd_mem[reg_addr[2:0]];
		end else if (in_lim) begin
			rd_mux = {`MSC_ZERO8, lim_mem[lim_off[3:0]]};
		end else begin
			case (reg_addr)
				`MSC_A_CFG:     rd_mux = {`MSC_ZERO8, cfg_reg};
				`MSC_A_STAT:    rd_mux = {`MSC_ZERO8, stat_reg};
				`MSC_A_MASK:    rd_mux = {`MSC_ZERO8, mask_reg};
				`MSC_A_RATE:    rd_mux = {`MSC_ZERO8, rate_reg};
				`MSC_A_OFF:     rd_mux = {`MSC_ZERO8, off_reg};
				`MSC_A_DEEP:    rd_mux = {`MSC_ZERO8, deep_reg};
				`MSC_A_ADV:     rd_mux = {`MSC_ZERO8, adv_reg};
				`MSC_A_BUSY:    rd_mux = {14'h0000, nrdy_reg,
					(state_reg == S_CONV) || (state_reg == S_UPD)};
				`MSC_A_MAKER:   rd_mux = {`MSC_ZERO8, `MSC_MAKER_VAL}; // value arbitrary
				`MSC_A_REV:     rd_mux = {`MSC_ZERO8, `MSC_REV_VAL}; // value arbitrary
				default:        rd_mux = `MSC_ZERO16;
			endcase
		end
	end

	// pins and read data held in flops; shutdown shows whenever no pass is active
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg      <= `MSC_ZERO16;
			vref_ext_reg   <= 1'b0;
			shutdown_reg   <= 1'b1;
			deep_sleep_reg <= 1'b0;
		end else begin
			if (reg_rd) begin
				rdata_reg <= rd_mux;
			end
			vref_ext_reg   <= adv_reg[`MSC_ADV_EXTREF];
			shutdown_reg   <= (state_reg == S_IDLE) || (state_reg == S_WAIT);
			deep_sleep_reg <= deep_b && (state_reg == S_IDLE);
		end
	end

	assign reg_rdata      = rdata_reg;
	assign conv_start     = conv_start_reg;
	assign conv_chan      = cur_reg;
	assign conv_temp      = conv_temp_reg;
	assign vref_ext       = vref_ext_reg;
	assign shutdown       = shutdown_reg;
	assign deep_sleep     = deep_sleep_reg;
	assign alert_pin_out  = alert_out_reg;
	assign alert_pin_oe_n = alert_oe_n_reg;

endmodule

`default_nettype wire

// *** msc_chk.sv ***
// concurrent checks on the ports of the monitor sequencer
`include "msc_defs.vh"
`default_nettype none
module msc_chk #(
	parameter [26:0] POR_CYC = 27'd16
) (
	input wire logic        clk_sys,
	input wire logic        arst_n,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        conv_start,
	input wire logic [2:0]  conv_chan,
	input wire logic        conv_temp,
	input wire logic        shutdown,
	input wire logic        deep_sleep,
	input wire logic        alert_pin_out,
	input wire logic        alert_pin_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  cfg_reg;
	logic [26:0] por_reg;
	logic        cfg_wr;
	logic        nrdy;
	logic        en_bit;
	logic        clr_bit;
	assign cfg_wr  = reg_wr && reg_addr == `MSC_A_CFG;
	assign nrdy    = por_reg < POR_CYC;
	assign en_bit  = cfg_reg[`MSC_CFG_INTEN];
	assign clr_bit = cfg_reg[`MSC_CFG_INTCLR];
	// -------------------------------------------------------------
	// shadow of control register and not-ready window
	// -------------------------------------------------------------
	// soft init restarts the window, so the shadow restarts too
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cfg_reg <= `MSC_CFG_RST;
			por_reg <= 27'd0;
		end else if (cfg_wr && reg_wdata[`MSC_CFG_INIT]) begin
			cfg_reg <= `MSC_CFG_RST;
			por_reg <= 27'd0;
		end else begin
			if (cfg_wr)
				cfg_reg <= reg_wdata;
			if (por_reg != POR_CYC + 27'd8)
				por_reg <= por_reg + 27'd1;
		end
	end
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	cfg_read_a : assert property (
		reg_rd && !reg_wr && reg_addr == `MSC_A_CFG |=> reg_rdata == {8'h00, $past(cfg_reg)})
		else $error("control readback differs from last write");
	busy_por_a : assert property (
		reg_rd && reg_addr == `MSC_A_BUSY && (por_reg + 27'd2 < POR_CYC || por_reg > POR_CYC + 27'd2)
		|=> reg_rdata[`MSC_BUSY_NRDY] == $past(nrdy)) else $error("not-ready flag wrong");
	oneshot_zero_a : assert property (
		reg_rd && reg_addr == `MSC_A_ONESHOT |=> reg_rdata == 16'h0000)
		else $error("trigger address read not zero");
	alert_off_a : assert property (
		!en_bit && !$past(en_bit) |-> alert_pin_oe_n) else $error("alert driven while disabled");
	alert_clear_a : assert property (
		clr_bit && $past(clr_bit) |-> alert_pin_oe_n) else $error("alert driven while cleared");
	drive_low_a : assert property (
		!alert_pin_oe_n |-> !alert_pin_out) else $error("alert pin not driven low");
	slot_gap_a : assert property (
		conv_start |=> !conv_start [*8]) else $error("slot shorter than nine cycles");
	volt_slot_a : assert property (
		conv_start ##1 !conv_temp |-> !conv_start [*8] ##1 !conv_start [*8])
		else $error("voltage slot too short");
	temp_chan_a : assert property (
		conv_temp |-> conv_chan == `MSC_TEMP_CH) else $error("temperature not on last channel");
	slot_awake_a : assert property (
		conv_start |=> !shutdown && !deep_sleep) else $error("asleep during a slot");
endmodule
bind msc_monitor msc_chk #(.POR_CYC(POR_CYC)) i_msc_chk (.*);
`default_nettype wire

// *** msc_far_model.sv ***
// converter and serial-pin model on the far side of the monitor
`default_nettype none
module msc_far_model (
	input  wire logic        clk_sys,
	input  wire logic        conv_start,
	input  wire logic [2:0]  conv_chan,
	input  wire logic        shutdown,
	input  wire logic        frame,
	output logic      [11:0] conv_result,
	output logic             scl_pin,
	output logic             sda_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] res [8];
	logic [2:0]  chan_log [64];
	int          cyc_log [64];
	int          n_start = 0;
	int          cyc = 0;
	logic        pend = 1'b0;
	// idle converter shows a changed value so a stale sample is seen
	assign conv_result = shutdown ? ~res[conv_chan] : res[conv_chan];
	initial begin
		for (int i = 0; i < 8; i++)
			res[i] = 12'h500;
		res[0] = 12'h900;
		res[3] = 12'h100;
		res[7] = 12'h064;
	end
	// log each slot start, channel taken once it has settled
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		pend <= conv_start;
		if (pend)
			chan_log[n_start - 1] <= conv_chan;
		if (conv_start && n_start < 64) begin
			cyc_log[n_start] <= cyc;
			n_start <= n_start + 1;
		end
	end
	// framing on pulled-up pins: start, clock at 80 ns, stop; idle high
	initial begin
		scl_pin = 1'b1;
		sda_pin = 1'b1;
		forever begin
			@(posedge frame);
			sda_pin = 1'b0;
			while (frame)
				#40 scl_pin = ~scl_pin;
			scl_pin = 1'b1;
			#40 sda_pin = 1'b1;
		end
	end
endmodule
`default_nettype wire

// *** test_msc_monitor.sv ***
// self-checking bench of the monitor sequencer
`include "msc_defs.vh"
`default_nettype none
module test_msc_monitor;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int VC = 20;
	localparam int LP = 200;
	localparam logic [7:0]  RA [10] = '{8'h0c, 8'h00, 8'h01, 8'h03, 8'h07, 8'h08, 8'h09,
		8'h0a, 8'h0b, 8'h50};
	localparam logic [15:0] RV [10] = '{16'h0002, 16'h0008, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	localparam int MODES [4] = '{0, 1, 3, 2};
	localparam int LAST [4] = '{6, 7, 5, 3};
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        frame = 1'b0;
	logic [15:0] reg_rdata;
	logic [15:0] d;
	logic [11:0] conv_result;
	logic [2:0]  conv_chan;
	logic [2:0]  exp_ch [8];
	logic        conv_start, conv_temp, vref_ext, shutdown, deep_sleep;
	logic        alert_pin_out, alert_pin_oe_n, scl_pin, sda_pin;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          b;
	int          k;
	int          dt;
	always #5 clk_sys = ~clk_sys;
	msc_monitor #(.VOLT_CYC(27'd20), .TEMP_CYC(27'd10), .LP_CYC(27'd200), .POR_CYC(27'd16))
	i_msc_monitor (.*);
	msc_far_model i_msc_far_model (.clk_sys(clk_sys), .conv_start(conv_start),
		.conv_chan(conv_chan), .shutdown(shutdown), .frame(frame),
		.conv_result(conv_result), .scl_pin(scl_pin), .sda_pin(sda_pin));
	// -------------------------------------------------------------
	// register port tasks and comparisons
	// -------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// read data is registered on the taking edge and sampled 1 ns after it
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] exp, input string m);
		logic [15:0] v;
		rd(a, v);
		chk(v, exp, m);
	endtask
	// bounded wait on the logged slot count
	task automatic wait_starts(input int n);
		for (int i = 0; i < 3000 && i_msc_far_model.n_start < n; i++)
			@(posedge clk_sys);
		chk({15'h0000, i_msc_far_model.n_start >= n}, 16'h0001, "slot wait");
	endtask
	task automatic chk_pin(input logic p, input logic e, input string m);
		#1 chk({15'h0000, p}, {15'h0000, e}, m);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// -------------------------------------------------------------
	// test sequence
	// -------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk_sys);
		arst_n <= 1'b1;
		for (int i = 0; i < 10; i++)
			rc(RA[i], RV[i], "reset value");
		for (int i = 0; i < 40; i++) begin
			rd(`MSC_A_BUSY, d);
			if (d[1] === 1'b0)
				break;
		end
		chk(d, 16'h0000, "ready after wait");
		$display("test reset done");
		for (int a = 8'h2a; a <= 8'h39; a++)
			wr(a[7:0], a[0] ? 8'h10 : 8'h80);
		wr(8'h38, 8'h19);
		wr(8'h39, 8'h14);
		wr(`MSC_A_RATE, 8'h01);
		wr(`MSC_A_OFF, 8'h02);
		// every mode, one pass each, channel 1 disabled
		for (int m = 0; m < 4; m++) begin
			// stop first, then let a full slot pass so an aborted slot is not a short one
			wr(`MSC_A_CFG, 8'h00);
			repeat (VC + 4) @(posedge clk_sys);
			wr(`MSC_A_ADV, {5'h00, 2'(MODES[m]), 1'b1});
			k = 0;
			for (int c = 0; c < 8; c++) begin
				if (c != 1 && (c <= LAST[m] || c == 7)) begin
					exp_ch[k] = 3'(c);
					k++;
				end
			end
			b = i_msc_far_model.n_start;
			wr(`MSC_A_CFG, 8'h01);
			wait_starts(b + k + 1);
			for (int i = 0; i < k; i++)
				chk(16'(i_msc_far_model.chan_log[b + i]), 16'(exp_ch[i]), "order");
			dt = i_msc_far_model.cyc_log[b + 1] - i_msc_far_model.cyc_log[b];
			chk(16'(dt), 16'(VC + 1), "voltage slot length");
		end
		chk_pin(vref_ext, 1'b1, "reference select");
		rc(8'h20, 16'h0900, "volt reading");
		rc(8'h23, 16'h0100, "volt reading");
		rc(8'h27, 16'h0064, "temp reading");
		$display("test modes done");
		wr(`MSC_A_CFG, 8'h03);
		repeat (3) @(posedge clk_sys);
		chk_pin(alert_pin_oe_n, 1'b0, "alert on fault");
		rc(`MSC_A_STAT, 16'h0089, "fault bits");
		wr(`MSC_A_MASK, 8'h89);
		rd(`MSC_A_STAT, d);
		b = i_msc_far_model.n_start;
		wait_starts(b + 5);
		chk_pin(alert_pin_oe_n, 1'b1, "masked alert");
		wr(`MSC_A_MASK, 8'h00);
		repeat (3) @(posedge clk_sys);
		chk_pin(alert_pin_oe_n, 1'b0, "unmasked alert");
		$display("test alert done");
		wr(`MSC_A_CFG, 8'h02);
		b = i_msc_far_model.n_start;
		repeat (60) @(posedge clk_sys);
		chk_pin(alert_pin_oe_n, 1'b0, "alert kept on stop");
		chk_pin(shutdown, 1'b1, "stopped");
		chk(16'(i_msc_far_model.n_start - b), 16'h0000, "no slots");
		rc(`MSC_A_OFF, 16'h0002, "reachable when stopped");
		rc(`MSC_A_STAT, 16'h0089, "status read");
		repeat (3) @(posedge clk_sys);
		chk_pin(alert_pin_oe_n, 1'b1, "read releases");
		wr(`MSC_A_CFG, 8'h03);
		b = i_msc_far_model.n_start;
		wait_starts(b + 5);
		wr(`MSC_A_CFG, 8'h0b);
		b = i_msc_far_model.n_start;
		repeat (60) @(posedge clk_sys);
		chk_pin(alert_pin_oe_n, 1'b1, "clear releases");
		chk(16'(i_msc_far_model.n_start - b), 16'h0000, "halted");
		rc(`MSC_A_STAT, 16'h0089, "status kept");
		$display("test stop done");
		wr(`MSC_A_CFG, 8'h00);
		wr(`MSC_A_DEEP, 8'h01);
		repeat (3) @(posedge clk_sys);
		chk_pin(deep_sleep, 1'b1, "deep entered");
		i_msc_far_model.res[0] = 12'h300;
		b = i_msc_far_model.n_start;
		wr(`MSC_A_ONESHOT, 8'h5a);
		wait_starts(b + 4);
		repeat (VC + 4) @(posedge clk_sys);
		chk(16'(i_msc_far_model.n_start - b), 16'h0004, "one pass");
		chk_pin(deep_sleep, 1'b1, "back to deep");
		rc(8'h20, 16'h0300, "one-shot reading");
		wr(`MSC_A_DEEP, 8'h00);
		repeat (3) @(posedge clk_sys);
		chk_pin(deep_sleep, 1'b0, "deep left");
		$display("test one-shot done");
		i_msc_far_model.res[0] = 12'h400;
		frame <= 1'b1;
		b = i_msc_far_model.n_start;
		wr(`MSC_A_ONESHOT, 8'h00);
		wait_starts(b + 1);
		repeat (VC + 4) @(posedge clk_sys);
		rc(8'h20, 16'h0300, "update held");
		frame <= 1'b0;
		// let the held one-shot pass finish before the low-power count starts
		repeat (100) @(posedge clk_sys);
		rc(8'h20, 16'h0400, "update after stop");
		$display("test bus hold done");
		wr(`MSC_A_RATE, 8'h00);
		b = i_msc_far_model.n_start;
		wr(`MSC_A_CFG, 8'h01);
		wait_starts(b + 4);
		repeat (40) @(posedge clk_sys);
		chk_pin(shutdown, 1'b1, "sleep after pass");
		wait_starts(b + 5);
		dt = i_msc_far_model.cyc_log[b + 4] - i_msc_far_model.cyc_log[b];
		chk({15'h0000, dt >= LP - 2 && dt <= LP + 3}, 16'h0001, "low-power period");
		$display("test low power done");
		wr(`MSC_A_CFG, 8'h80);
		rd(`MSC_A_BUSY, d);
		chk({15'h0000, d[1]}, 16'h0001, "not ready again");
		rc(`MSC_A_CFG, 16'h0008, "init self-clears");
		rc(`MSC_A_RATE, 16'h0000, "init default");
		rc(8'h20, 16'h0400, "reading kept");
		rc(8'h2a, 16'h0080, "limit kept");
		$display("test soft init done");
		conclude();
	end
	// hang guard, far beyond the few thousand cycles the tests need
	initial begin
		#200us;
		n_mismatch++;
		$display("ERROR %0t: watchdog expired", $time);
		conclude();
	end
endmodule
`default_nettype wire
